// [src/asc_pkg.sv]
package asc_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] ASC_CON1_OFF = 12'h000;
  localparam logic [11:0] ASC_CON2_OFF = 12'h004;
  localparam logic [11:0] ASC_CON3_OFF = 12'h008;
  localparam logic [15:0] ASC_CON_RST  = 16'h0000;
  localparam logic [15:0] ASC_WMASK [3] = '{16'hB7EC, 16'hE73F, 16'h9F3F};
  localparam logic [15:0] ASC_SIM_M    = 16'h0008;
  localparam logic [15:0] ASC_CHCNT_M  = 16'h0300;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int ASC_ON_BIT    = 15;
  localparam int ASC_SIDL_BIT  = 13;
  localparam int ASC_DMABM_BIT = 12;
  localparam int ASC_RES12_BIT = 10;
  localparam int ASC_FORM_LSB  = 8;
  localparam int ASC_TRIG_LSB  = 5;
  localparam int ASC_SIM_BIT   = 3;
  localparam int ASC_AUTO_SAMPLE_START_BIT  = 2;
  localparam int ASC_SAMPLE_ACTIVE_BIT  = 1;
  localparam int ASC_DONE_BIT  = 0;
  localparam int ASC_REF_LSB   = 13;
  localparam int ASC_SCAN_BIT  = 10;
  localparam int ASC_CHCNT_LSB = 8;
  localparam int ASC_BUFFER_HALF_STATUS_BIT  = 7;
  localparam int ASC_SMPI_LSB  = 2;
  localparam int ASC_SPLIT_BIT = 1;
  localparam int ASC_ALTERNATE_SAMPLE_BIT  = 0;
  localparam int ASC_RC_BIT    = 15;
  localparam int ASC_SAMC_LSB  = 8;
  localparam int ASC_DIV_LSB   = 0;

  // ----------------------------------------------------------------------
  // codes and counts
  // ----------------------------------------------------------------------
  localparam logic [2:0] ASC_TRIG_SW    = 3'h0;
  localparam logic [2:0] ASC_TRIG_PIN   = 3'h1;
  localparam logic [2:0] ASC_TRIG_TIMER = 3'h2;
  localparam logic [2:0] ASC_TRIG_PWM   = 3'h3;
  localparam logic [2:0] ASC_TRIG_AUTO  = 3'h7;
  localparam logic [4:0] ASC_SAMC_MAX   = 5'h1F;

  typedef enum logic [2:0] {
    ASC_HOLD   = 3'b001,
    ASC_SAMPLE = 3'b010,
    ASC_CONV   = 3'b100
  } asc_state_t;

endpackage : asc_pkg

// [src/asc_sequence_control.sv]
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps

module asc_sequence_control
  import asc_pkg::*;
(
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // device state and trigger sources
  input  wire logic        idle_mode,
  input  wire logic        trig_pin,
  input  wire logic        trig_timer,
  input  wire logic        trig_pwm,
  input  wire logic        rc_tick,
  // converter core
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_data,
  output logic             conv_start,
  output logic             module_active,
  output logic             sampling,
  output logic             res12_mode,
  output logic             ref_pos_ext,
  output logic             ref_neg_ext,
  output logic             sim_sample,
  output logic [1:0]       chan_count,
  output logic             scan_active,
  output logic             use_sample_b,
  output logic             rc_clock_sel,
  output logic             tad_tick,
  // results and dma
  input  wire logic [4:0]  analog_index,
  input  wire logic [2:0]  dma_buf_len,
  output logic             result_valid,
  output logic [15:0]      result_word,
  output logic [1:0]       result_chan,
  output logic [11:0]      dma_addr,
  output logic             dma_req,
  output logic             converter_irq_flag
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function automatic logic [1:0] asc_decode(input logic [11:0] a);
    logic [1:0] r;
    r = 2'h3;
    if (a == ASC_CON1_OFF) r = 2'h0;
    if (a == ASC_CON2_OFF) r = 2'h1;
    if (a == ASC_CON3_OFF) r = 2'h2;
    return r;
  endfunction : asc_decode

  function automatic logic [15:0] asc_format(input logic [11:0] d, input logic r12,
                                             input logic [1:0] f);
    logic [15:0] w;
    w = 16'h0000;
    if (r12) begin
      unique case (f)
        2'h0: w = {4'h0, d};
        2'h1: w = {{5{~d[11]}}, d[10:0]};
        2'h2: w = {d, 4'h0};
        2'h3: w = {~d[11], d[10:0], 4'h0};
      endcase
    end else begin
      unique case (f)
        2'h0: w = {6'h00, d[9:0]};
        2'h1: w = {{7{~d[9]}}, d[8:0]};
        2'h2: w = {d[9:0], 6'h00};
        2'h3: w = {~d[9], d[8:0], 6'h00};
      endcase
    end
    return w;
  endfunction : asc_format

  // ----------------------------------------------------------------------
  // registers and fields
  // ----------------------------------------------------------------------
  logic [15:0] con_reg  [3];
  logic [15:0] con_next [3];
  asc_state_t  state_reg, state_next;
  logic        wr_pend_reg;
  logic [1:0]  wr_idx_reg;
  logic        done_reg;
  logic        done_next;
  logic [5:0]  div_cnt_reg;
  logic [4:0]  sample_active_cnt_reg;
  logic [1:0]  ch_cnt_reg;
  logic [3:0]  op_cnt_reg;
  logic [3:0]  buf_ptr_reg;
  logic        half_reg;
  logic [6:0]  slot_reg;
  logic        on_d_reg;

  wire       module_on  = con_reg[0][ASC_ON_BIT];
  wire       stop_idle  = con_reg[0][ASC_SIDL_BIT];
  wire       dmabm      = con_reg[0][ASC_DMABM_BIT];
  wire       res12      = con_reg[0][ASC_RES12_BIT];
  wire [1:0] form       = con_reg[0][ASC_FORM_LSB +: 2];
  wire [2:0] trig       = con_reg[0][ASC_TRIG_LSB +: 3];
  wire       auto_sample_start       = con_reg[0][ASC_AUTO_SAMPLE_START_BIT];
  wire [2:0] refsel     = con_reg[1][ASC_REF_LSB +: 3];
  wire [1:0] chcnt      = res12 ? 2'h0 : con_reg[1][ASC_CHCNT_LSB +: 2];
  wire [3:0] smpi       = con_reg[1][ASC_SMPI_LSB +: 4];
  wire       split      = con_reg[1][ASC_SPLIT_BIT];
  wire       alternate_sample       = con_reg[1][ASC_ALTERNATE_SAMPLE_BIT];
  wire       rc_sel     = con_reg[2][ASC_RC_BIT];
  wire [4:0] samc       = con_reg[2][ASC_SAMC_LSB +: 5];
  wire [5:0] adcs       = con_reg[2][ASC_DIV_LSB +: 6];

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire       take     = hsel & htrans[1] & hready;
  wire [1:0] a_idx    = asc_decode(haddr);
  wire       wr1      = wr_pend_reg & (wr_idx_reg == 2'h0);
  wire       running  = module_on & ~(stop_idle & idle_mode);
  wire       sw_set   = wr1 & hwdata[ASC_SAMPLE_ACTIVE_BIT];
  wire       sw_end   = wr1 & ~hwdata[ASC_SAMPLE_ACTIVE_BIT] & (trig == ASC_TRIG_SW);
  // a sample time lowered while sampling still ends the sample instead of hanging
  wire       samc_hit = sample_active_cnt_reg >= samc;
  wire       conv_tk  = (state_reg == ASC_CONV) & conv_done;
  wire [1:0] nch_m1   = chcnt[1] ? 2'h3 : {1'b0, chcnt[0]};
  wire       seq_end  = conv_tk & (ch_cnt_reg == nch_m1);
  wire       evt      = seq_end & (op_cnt_reg == smpi);
  wire       on_rise  = module_on & ~on_d_reg;
  wire [7:0] blk      = 8'h01 << dma_buf_len;
  wire [6:0] blk_m1   = 7'(blk - 8'h01);
  wire [11:0] sg_addr = (12'(analog_index) << dma_buf_len) | {5'h00, slot_reg & blk_m1};

  logic end_sample;
  always_comb begin
    unique case (trig)
      ASC_TRIG_SW:    end_sample = sw_end;
      ASC_TRIG_PIN:   end_sample = trig_pin;
      ASC_TRIG_TIMER: end_sample = trig_timer;
      ASC_TRIG_PWM:   end_sample = trig_pwm;
      ASC_TRIG_AUTO:  end_sample = samc_hit;
      default:        end_sample = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_con
      assign con_next[gi] = (wr_pend_reg && wr_idx_reg == 2'(gi)) ?
                            (hwdata[15:0] & ASC_WMASK[gi]) : con_reg[gi];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) con_reg[gi] <= ASC_CON_RST;
        else          con_reg[gi] <= con_next[gi];
      end
    end
  endgenerate

  // read data is built from next values so a read right after a write sees it
  wire        r12n = con_next[0][ASC_RES12_BIT];
  wire [15:0] rd1  = (con_next[0] & (r12n ? ~ASC_SIM_M : 16'hFFFF)) |
                     (16'(state_reg == ASC_SAMPLE) << ASC_SAMPLE_ACTIVE_BIT) |
                     (16'(done_next) << ASC_DONE_BIT);
  wire [15:0] rd2  = (con_next[1] & (r12n ? ~ASC_CHCNT_M : 16'hFFFF)) |
                     (16'(half_reg) << ASC_BUFFER_HALF_STATUS_BIT);
  wire [15:0] rd_w = (a_idx == 2'h0) ? rd1 : (a_idx == 2'h1) ? rd2 :
                     (a_idx == 2'h2) ? con_next[2] : 16'h0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 2'h3;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b0;
      hresp       <= 1'b0;
    end else begin
      wr_pend_reg <= take & hwrite;
      wr_idx_reg  <= a_idx;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      if (take && !hwrite) hrdata <= {16'h0000, rd_w};
    end
  end

  // ----------------------------------------------------------------------
  // done flag: hardware set wins over a software clear
  // ----------------------------------------------------------------------
  always_comb begin
    done_next = done_reg;
    if (wr1 && !hwdata[ASC_DONE_BIT]) done_next = 1'b0;
    if (state_reg == ASC_SAMPLE && end_sample) done_next = 1'b0;
    if (seq_end) done_next = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) done_reg <= 1'b0;
    else          done_reg <= done_next;
  end

  // ----------------------------------------------------------------------
  // sequence state machine
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ASC_HOLD:   if (sw_set || auto_sample_start) state_next = ASC_SAMPLE;
      ASC_SAMPLE: if (end_sample) state_next = ASC_CONV;
      ASC_CONV:   if (seq_end) state_next = auto_sample_start ? ASC_SAMPLE : ASC_HOLD;
      default:    state_next = ASC_HOLD;
    endcase
    if (!running) state_next = ASC_HOLD;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg  <= ASC_HOLD;
      sampling   <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      state_reg  <= state_next;
      sampling   <= state_next == ASC_SAMPLE;
      conv_start <= (state_reg == ASC_SAMPLE) && (state_next == ASC_CONV);
    end
  end

  // ----------------------------------------------------------------------
  // conversion clock and sample timer
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_reg <= 6'h00;
      tad_tick    <= 1'b0;
    end else if (!running || rc_sel) begin
      div_cnt_reg <= 6'h00;
      tad_tick    <= running & rc_tick;
    end else begin
      tad_tick    <= div_cnt_reg == adcs;
      div_cnt_reg <= (div_cnt_reg == adcs) ? 6'h00 : div_cnt_reg + 6'h01;
    end
  end

  // saturates so a 31-period setting cannot wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                      sample_active_cnt_reg <= 5'h00;
    else if (state_reg != ASC_SAMPLE)  sample_active_cnt_reg <= 5'h00;
    else if (tad_tick && sample_active_cnt_reg != ASC_SAMC_MAX)
      sample_active_cnt_reg <= sample_active_cnt_reg + 5'h01;
  end

  // ----------------------------------------------------------------------
  // channel, rate and buffer bookkeeping
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ch_cnt_reg <= 2'h0;
      on_d_reg   <= 1'b0;
    end else begin
      on_d_reg <= module_on;
      if (state_reg != ASC_CONV) ch_cnt_reg <= 2'h0;
      else if (conv_tk)          ch_cnt_reg <= seq_end ? 2'h0 : ch_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_cnt_reg  <= 4'h0;
      buf_ptr_reg <= 4'h0;
      half_reg    <= 1'b0;
      slot_reg    <= 7'h00;
    end else if (on_rise) begin
      op_cnt_reg  <= 4'h0;
      buf_ptr_reg <= 4'h0;
      half_reg    <= 1'b0;
      slot_reg    <= 7'h00;
    end else if (evt) begin
      op_cnt_reg  <= 4'h0;
      half_reg    <= split & ~half_reg;
      buf_ptr_reg <= split ? {~half_reg, 3'h0} : 4'h0;
      slot_reg    <= slot_reg + 7'h01;
    end else begin
      if (seq_end) op_cnt_reg <= op_cnt_reg + 4'h1;
      if (conv_tk) buf_ptr_reg <= buf_ptr_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // result, dma and flag outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_valid       <= 1'b0;
      result_word        <= 16'h0000;
      result_chan        <= 2'h0;
      dma_addr           <= 12'h000;
      dma_req            <= 1'b0;
      converter_irq_flag <= 1'b0;
    end else begin
      result_valid       <= conv_tk;
      converter_irq_flag <= evt;
      dma_req            <= evt;
      if (conv_tk) begin
        result_word <= asc_format(conv_data, res12, form);
        result_chan <= ch_cnt_reg;
        dma_addr    <= dmabm ? {8'h00, buf_ptr_reg} : sg_addr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      module_active <= 1'b0;
      res12_mode    <= 1'b0;
      ref_pos_ext   <= 1'b0;
      ref_neg_ext   <= 1'b0;
      sim_sample    <= 1'b0;
      chan_count    <= 2'h0;
      scan_active   <= 1'b0;
      use_sample_b  <= 1'b0;
      rc_clock_sel  <= 1'b0;
    end else begin
      module_active <= running;
      res12_mode    <= res12;
      ref_pos_ext   <= ~refsel[2] & refsel[0];
      ref_neg_ext   <= ~refsel[2] & refsel[1];
      sim_sample    <= ~res12 & con_reg[0][ASC_SIM_BIT] & (chcnt != 2'h0);
      chan_count    <= chcnt;
      scan_active   <= con_reg[1][ASC_SCAN_BIT] & ~use_sample_b;
      rc_clock_sel  <= rc_sel;
      if (!alternate_sample)        use_sample_b <= 1'b0;
      else if (seq_end) use_sample_b <= ~use_sample_b;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_off_holds : assert property (
    !module_on |=> state_reg == ASC_HOLD && !sampling)
    else $error("sequencer active while module off");
  chk_idle_stop : assert property (
    (module_on && stop_idle && idle_mode) |=> !module_active)
    else $error("module kept running in idle");
  chk_done_start : assert property (
    conv_start |-> !done_reg)
    else $error("done still set at conversion start");
  chk_done_set : assert property (
    seq_end |=> done_reg && !conv_start)
    else $error("done not set after sequence");
  chk_manual_hold : assert property (
    (state_reg == ASC_SAMPLE && trig == ASC_TRIG_SW && !sw_end && running)
    |=> state_reg == ASC_SAMPLE)
    else $error("manual sampling ended without software");
  chk_auto_restart : assert property (
    (seq_end && auto_sample_start && running) |=> sampling)
    else $error("auto start did not resume sampling");
  chk_event_rate : assert property (
    converter_irq_flag |-> $past(op_cnt_reg) == $past(smpi) && op_cnt_reg == 4'h0)
    else $error("event raised at wrong operation count");
  chk_dma_pair : assert property (
    converter_irq_flag |-> dma_req)
    else $error("flag raised without dma request");
  chk_rate_restart : assert property (
    $rose(module_on) |=> op_cnt_reg == 4'h0)
    else $error("rate counter not restarted");
  chk_half_flip : assert property (
    (evt && split && !on_rise) |=> half_reg != $past(half_reg) && buf_ptr_reg[2:0] == 3'h0)
    else $error("split buffer half not alternated");

endmodule : asc_sequence_control

// [verif/asc_core_model.sv]
`timescale 1ns/100ps

module asc_core_model (
  // clock
  input  wire logic        hclk,
  // sequencer side
  input  wire logic        conv_start,
  input  wire logic [1:0]  chan_count,
  input  wire logic        res12_mode,
  // bench control
  input  wire logic [11:0] data_in,
  input  wire logic [3:0]  lag,
  // results
  output logic             conv_done,
  output logic [11:0]      conv_data
);
  // --------------------------------------------------------------
  // one result per channel, each after a settable delay
  // --------------------------------------------------------------
  int n;
  initial begin
    conv_done = 1'b0;
    conv_data = 12'h0000;
    forever begin
      @(posedge hclk);
      if (conv_start === 1'b1) begin
        n = (res12_mode || chan_count == 2'b00) ? 1 : (chan_count == 2'b01) ? 2 : 4;
        repeat (n) begin
          repeat (int'(lag) + 1) @(posedge hclk);
          conv_done <= 1'b1;
          conv_data <= data_in;
          @(posedge hclk);
          conv_done <= 1'b0;
          // stale data never left on the wire
          conv_data <= ~data_in;
        end
      end
    end
  end
endmodule : asc_core_model

// [verif/asc_sequence_control_test.sv]
`timescale 1ns/100ps

module asc_sequence_control_test;
  import asc_pkg::*;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, idle_mode;
  logic        trig_pin, trig_timer, trig_pwm, rc_tick, conv_done, conv_start;
  logic        module_active, sampling, res12_mode, ref_pos_ext, ref_neg_ext;
  logic        sim_sample, scan_active, use_sample_b, rc_clock_sel, tad_tick;
  logic        result_valid, dma_req, converter_irq_flag, hresp;
  logic [11:0] haddr, conv_data, dma_addr, core_data, last_addr;
  logic [1:0]  htrans, chan_count, result_chan, rc_cnt, last_chan;
  logic [2:0]  hsize, buf_len;
  logic [31:0] hwdata, hrdata;
  logic [15:0] result_word, last_word;
  logic [3:0]  core_lag;
  logic        alt_at_irq [2];
  int          n_errors, samples_checked, start_n, irq_n, res_n, tad_n, start_at_irq;

  asc_sequence_control asc_sequence_control_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .idle_mode(idle_mode),
    .trig_pin(trig_pin), .trig_timer(trig_timer), .trig_pwm(trig_pwm), .rc_tick(rc_tick),
    .conv_done(conv_done), .conv_data(conv_data), .conv_start(conv_start),
    .module_active(module_active), .sampling(sampling), .res12_mode(res12_mode),
    .ref_pos_ext(ref_pos_ext), .ref_neg_ext(ref_neg_ext), .sim_sample(sim_sample),
    .chan_count(chan_count), .scan_active(scan_active), .use_sample_b(use_sample_b),
    .rc_clock_sel(rc_clock_sel), .tad_tick(tad_tick), .analog_index(5'h13),
    .dma_buf_len(buf_len), .result_valid(result_valid), .result_word(result_word),
    .result_chan(result_chan), .dma_addr(dma_addr), .dma_req(dma_req),
    .converter_irq_flag(converter_irq_flag));

  asc_core_model asc_core_model_i (
    .hclk(hclk), .conv_start(conv_start), .chan_count(chan_count),
    .res12_mode(res12_mode), .data_in(core_data), .lag(core_lag),
    .conv_done(conv_done), .conv_data(conv_data));

  always #12.5 hclk = ~hclk;

  always @(posedge hclk) begin
    rc_cnt <= rc_cnt + 2'd1;
    rc_tick <= (rc_cnt == 2'd3);
  end

  // sampled mid-cycle so registered outputs have settled
  always @(negedge hclk) begin
    if (conv_start === 1'b1) start_n++;
    if (tad_tick === 1'b1) tad_n++;
    if (result_valid === 1'b1) begin
      res_n++;
      last_word = result_word;
      last_addr = dma_addr;
      last_chan = result_chan;
    end
    if ((dma_req | converter_irq_flag) === 1'b1) chk("dma_req", 1, dma_req);
    if (converter_irq_flag === 1'b1) begin
      alt_at_irq[irq_n % 2] = use_sample_b;
      irq_n++;
      start_at_irq = start_n;
    end
  end

  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_cnt(ref int c, input int tgt);
    for (int k = 0; k < 400 && c < tgt; k++) @(posedge hclk);
    if (c < tgt) begin
      n_errors++;
      final_report();
    end
  endtask : wait_cnt

  task automatic rdy();
    int k;
    k = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      k++;
      if (k > 50) begin
        n_errors++;
        final_report();
      end
      @(posedge hclk);
    end
  endtask : rdy

  task automatic bus(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    rdy();
    r = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
    logic [31:0] r;
    bus(1'b0, a, 16'h0000, r);
    chk(nm, e, r);
    chk("hresp", 0, hresp);
  endtask : rdc

  task automatic settle();
    repeat (2) @(negedge hclk);
  endtask : settle

  function automatic logic [15:0] fmt(input logic r12, input logic [1:0] f,
                                      input logic [11:0] d);
    logic s;
    s = r12 ? ~d[11] : ~d[9];
    case ({r12, f})
      3'b000: fmt = {6'h00, d[9:0]};
      3'b001: fmt = {{7{s}}, d[8:0]};
      3'b010: fmt = {d[9:0], 6'h00};
      3'b011: fmt = {s, d[8:0], 6'h00};
      3'b100: fmt = {4'h0, d};
      3'b101: fmt = {{5{s}}, d[10:0]};
      3'b110: fmt = {d, 4'h0};
      default: fmt = {s, d[10:0], 4'h0};
    endcase
  endfunction : fmt

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    rdc(ASC_CON1_OFF, 32'h0000_0000, "con1");
    rdc(12'h00C, 32'h0000_0000, "unmapped");
    wr(12'h00C, 16'hFFFF);
    wr(ASC_CON2_OFF, 16'hFFFF);
    wr(ASC_CON3_OFF, 16'hFFFF);
    rdc(ASC_CON2_OFF, 32'h0000_E73F, "con2");
    rdc(ASC_CON3_OFF, 32'h0000_9F3F, "con3");
    chk("rc_sel", 1, rc_clock_sel);
    for (int i = 0; i < 8; i++) begin
      wr(ASC_CON2_OFF, 16'(i << 13) | 16'h0508);
      settle();
      chk("ref_pos", (i == 1 || i == 3), ref_pos_ext);
      chk("ref_neg", (i == 2 || i == 3), ref_neg_ext);
    end
    chk("scan", 1, scan_active);
    wr(ASC_CON1_OFF, 16'h0008);
    settle();
    chk("sim", 1, sim_sample);
    wr(ASC_CON1_OFF, 16'h0408);
    settle();
    rdc(ASC_CON1_OFF, 32'h0000_0400, "con1");
    rdc(ASC_CON2_OFF, 32'h0000_E408, "con2");
    chk("res12", 1, res12_mode);
    chk("chans", 0, {sim_sample, chan_count});
  endtask : t_regs

  task automatic t_format();
    logic [15:0] c;
    int n;
    wr(ASC_CON2_OFF, 16'h0100);
    for (int i = 0; i < 8; i++) begin
      c = 16'h8000 | 16'(i[2]) << 10 | 16'(i[1:0]) << 8;
      core_data = i[0] ? 12'hA5C : 12'h1B6;
      core_lag = 4'(i);
      wr(ASC_CON1_OFF, 16'h0000);
      buf_len <= 3'(i);
      wr(ASC_CON1_OFF, c);
      wr(ASC_CON1_OFF, c | 16'h0002);
      settle();
      chk("sampling", 1, sampling);
      n = res_n;
      wr(ASC_CON1_OFF, c);
      wait_cnt(res_n, n + (i[2] ? 1 : 2));
      chk("result", fmt(i[2], i[1:0], core_data), last_word);
      chk("chan", i[2] ? 0 : 1, last_chan);
      chk("dma_addr", 32'(12'h013 << i), last_addr);
      settle();
      rdc(ASC_CON1_OFF, c | 16'h0001, "done");
    end
  endtask : t_format

  task automatic t_trig();
    int n;
    for (int i = 1; i < 5; i++) begin
      wr(ASC_CON1_OFF, 16'h8400 | 16'(i << 5));
      wr(ASC_CON1_OFF, 16'h8402 | 16'(i << 5));
      n = start_n;
      @(posedge hclk);
      trig_pin <= (i == 1 || i == 4);
      trig_timer <= (i == 2 || i == 4);
      trig_pwm <= (i == 3 || i == 4);
      @(posedge hclk);
      trig_pin <= 1'b0;
      trig_timer <= 1'b0;
      trig_pwm <= 1'b0;
      repeat (3) settle();
      chk("start", (i < 4) ? n + 1 : n, start_n);
      chk("sampling", (i == 4), sampling);
    end
  endtask : t_trig

  task automatic t_auto();
    int n;
    int s;
    wr(ASC_CON1_OFF, 16'h0000);
    wr(ASC_CON3_OFF, 16'h0201);
    wr(ASC_CON2_OFF, 16'h000B);
    n = irq_n;
    s = start_n;
    wr(ASC_CON1_OFF, 16'h94E4);
    wait_cnt(irq_n, n + 1);
    chk("ops", s + 3, start_at_irq);
    chk("dma_addr", 32'h0000_0002, last_addr);
    rdc(ASC_CON2_OFF, 32'h0000_008B, "half");
    wait_cnt(irq_n, n + 2);
    chk("ops", s + 6, start_at_irq);
    chk("dma_addr", 32'h0000_000A, last_addr);
    chk("alt", 1, alt_at_irq[0] ^ alt_at_irq[1]);
    rdc(ASC_CON2_OFF, 32'h0000_000B, "half");
    n = tad_n;
    repeat (40) @(posedge hclk);
    chk("tad", n + 20, tad_n);
    wr(ASC_CON3_OFF, 16'h8000);
    settle();
    n = tad_n;
    repeat (40) @(posedge hclk);
    chk("tad_rc", n + 10, tad_n);
  endtask : t_auto

  task automatic t_idle();
    wr(ASC_CON1_OFF, 16'h0000);
    wr(ASC_CON1_OFF, 16'hA000);
    idle_mode <= 1'b1;
    settle();
    chk("active", 0, module_active);
    wr(ASC_CON1_OFF, 16'h8000);
    settle();
    chk("active", 1, module_active);
    wr(ASC_CON1_OFF, 16'h0000);
    settle();
    chk("active", 0, module_active);
  endtask : t_idle

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    buf_len = 3'h0;
    hwdata = 32'h0000_0000;
    idle_mode = 1'b0;
    trig_pin = 1'b0;
    trig_timer = 1'b0;
    trig_pwm = 1'b0;
    rc_tick = 1'b0;
    rc_cnt = 2'd0;
    core_data = 12'h000;
    core_lag = 4'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    t_regs();
    t_format();
    t_trig();
    t_auto();
    t_idle();
    final_report();
  end
endmodule : asc_sequence_control_test
